// ---- csw_regs.vh ----
// Register offsets, field positions and reset values of the select decoder
`ifndef CSW_REGS_VH
`define CSW_REGS_VH

// ****************************************************************
// Register offsets in the I/O space (low address byte)
// ****************************************************************
`define CSW_LBR0_OFF     8'hA8
`define CSW_UBR0_OFF     8'hA9
`define CSW_CTL0_OFF     8'hAA
`define CSW_LBR1_OFF     8'hAB
`define CSW_UBR1_OFF     8'hAC
`define CSW_CTL1_OFF     8'hAD
`define CSW_LBR2_OFF     8'hAE
`define CSW_UBR2_OFF     8'hAF
`define CSW_CTL2_OFF     8'hB0
`define CSW_LBR3_OFF     8'hB1
`define CSW_UBR3_OFF     8'hB2
`define CSW_CTL3_OFF     8'hB3

// ****************************************************************
// Control register fields
// ****************************************************************
`define CSW_WAIT_HI      7
`define CSW_WAIT_LO      5
`define CSW_IO_BIT       4
`define CSW_EN_BIT       3

// ****************************************************************
// Reset values
// ****************************************************************
`define CSW_CTL0_RST     8'hE8
`define CSW_CTLN_RST     8'h00
`define CSW_BOUND_RST    8'h00

// ****************************************************************
// Address map, idle read data and zero wait constants
// ****************************************************************
`define CSW_PERIPH_MIN   8'h80
`define CSW_TOP_ZERO     8'h00
`define CSW_RD_IDLE      8'h00
`define CSW_WAIT_ZERO    3'h0

`endif

// ---- csw_decoder.v ----
// Chip select and wait state decoder with its select registers
`timescale 1ns/10ps
`include "csw_regs.vh"

// What this block does
// [RULE1] I/O cycles drive top byte zero, 16-bit address
// [RULE2] Unused peripheral addresses: reads zero, writes nothing
// [RULE3] I/O selects assert only during I/O instructions
// [RULE4] I/O match compares address bits 11:4 to lower
// [RULE5] I/O decode ignores top byte and page base
// [RULE6] Four selects, each memory or I/O
// [RULE7] I/O select needs enable and I/O bits set
// [RULE8] Lowest numbered qualifying select wins
// [RULE9] No external I/O select for low byte 80h-FFh
// [RULE10] I/O select drives select and request strobe low
// [RULE11] Memory select compares top byte with upper bound
// [RULE12] Memory range bounds are both inclusive
// [RULE13] Control bits 7:5 give zero to seven waits
// [RULE14] Control bit 4 picks memory or I/O select
// [RULE15] Control reset: select zero E8h, others 00h
// [RULE16] Each wait stretches the asserted cycle one clock
module csw_decoder (
    input  wire        clock_in,        // System clock, 200 MHz
    input  wire        srst_in,         // Synchronous reset, active high
    input  wire        cycle_start_in,  // One-cycle pulse: new bus cycle
    input  wire        cycle_io_in,     // 1 = I/O instruction, 0 = memory
    input  wire        cycle_write_in,  // 1 = write, 0 = read
    input  wire [23:0] cycle_addr_in,   // Address from the core
    input  wire [7:0]  cycle_wdata_in,  // Write data from the core
    output reg  [23:0] addr_out,        // Address bus to the pins
    output reg         select_out_zero_n_out,  // Select 0, active low
    output reg         select_out_one_n_out,   // Select 1, active low
    output reg         select_out_two_n_out,   // Select 2, active low
    output reg         select_out_three_n_out, // Select 3, active low
    output reg         io_request_strobe_n_out, // I/O strobe, active low
    output reg         cycle_busy_out,  // High while a cycle is running
    output reg         cycle_done_out,  // One-cycle pulse: cycle ends
    output reg  [7:0]  reg_rdata_out    // Read data of on-chip registers
);

    // ****************************************************************
    // States of the bus cycle sequencer
    // ****************************************************************
    localparam ST_IDLE   = 1'b0;        // Waiting for a cycle request
    localparam ST_ACTIVE = 1'b1;        // Cycle driven, waits counting

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg  [7:0] ctl_reg [0:3];           // Control: wait, type, enable
    reg  [7:0] lbr_reg [0:3];           // Lower bound bytes
    reg  [7:0] ubr_reg [0:3];           // Upper bound bytes
    reg        state_reg;               // Sequencer state
    reg        state_next;              // Its next value
    reg  [2:0] wait_reg;                // Waits still to insert
    reg  [2:0] wait_next;               // Its next value
    reg  [3:0] sel_next;                // Select vector, one-hot, high
    reg        io_request_strobe_next;               // I/O strobe request, high
    reg        periph_hit;              // Access lands on on-chip range
    reg  [1:0] reg_idx;                 // Index of addressed select
    reg  [1:0] reg_kind;                // 0 lower, 1 upper, 2 control
    reg        reg_hit;                 // Address is an implemented reg
    reg  [7:0] rd_next;                 // Read data for this access
    // Each process has its own loop index, so that no variable has two
    // drivers and no combinational block wakes another through it
    integer    i_sel;                   // Loop index of the select decode
    integer    i_wait;                  // Loop index of the wait pick
    integer    i_rst;                   // Loop index of the bound reset

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Memory range test: both bounds inclusive on the top byte
    function mem_match;
        input [7:0] top;
        input [7:0] lo;
        input [7:0] hi;
        begin
            mem_match = (top >= lo) && (top <= hi); // [RULE11] [RULE12]
        end
    endfunction

    // Keeps only the lowest set bit of a request vector
    function [3:0] first_hit;
        input [3:0] req;
        begin
            if (req[0]) begin
                first_hit = 4'h1;
            end else if (req[1]) begin
                first_hit = 4'h2;
            end else if (req[2]) begin
                first_hit = 4'h4;
            end else if (req[3]) begin
                first_hit = 4'h8;
            end else begin
                first_hit = 4'h0;
            end
        end
    endfunction

    // Wait field of a control byte
    function [2:0] wait_of;
        input [7:0] ctl;
        begin
            wait_of = ctl[`CSW_WAIT_HI:`CSW_WAIT_LO]; // [RULE13]
        end
    endfunction

    // ****************************************************************
    // On-chip register decode
    // ****************************************************************

    // Finds which select register, if any, the low byte names
    always @* begin
        reg_hit  = 1'b0;
        reg_idx  = 2'd0;
        reg_kind = 2'd0;
        case (cycle_addr_in[7:0])
            `CSW_LBR0_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd0;
                reg_kind = 2'd0;
            end
            `CSW_UBR0_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd0;
                reg_kind = 2'd1;
            end
            `CSW_CTL0_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd0;
                reg_kind = 2'd2;
            end
            `CSW_LBR1_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd1;
                reg_kind = 2'd0;
            end
            `CSW_UBR1_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd1;
                reg_kind = 2'd1;
            end
            `CSW_CTL1_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd1;
                reg_kind = 2'd2;
            end
            `CSW_LBR2_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd2;
                reg_kind = 2'd0;
            end
            `CSW_UBR2_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd2;
                reg_kind = 2'd1;
            end
            `CSW_CTL2_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd2;
                reg_kind = 2'd2;
            end
            `CSW_LBR3_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd3;
                reg_kind = 2'd0;
            end
            `CSW_UBR3_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd3;
                reg_kind = 2'd1;
            end
            `CSW_CTL3_OFF: begin
                reg_hit  = 1'b1;
                reg_idx  = 2'd3;
                reg_kind = 2'd2;
            end
            default: begin
                // Not a select register: unmapped or another peripheral
                reg_hit = 1'b0;
            end
        endcase
    end

    // Read data: unmapped peripheral addresses read as zero
    always @* begin
        rd_next = `CSW_RD_IDLE;
        if (reg_hit) begin
            case (reg_kind)
                2'd0:    rd_next = lbr_reg[reg_idx];
                2'd1:    rd_next = ubr_reg[reg_idx];
                default: rd_next = ctl_reg[reg_idx];
            endcase
        end
    end

    // ****************************************************************
    // Select decode for a new cycle
    // ****************************************************************

    // Computes the select vector and strobe for the requested cycle
    always @* begin
        // Page base and top byte play no part in the I/O decode
        periph_hit = cycle_io_in &&
            (cycle_addr_in[7:0] >= `CSW_PERIPH_MIN);        // [RULE9]
        sel_next   = 4'h0;
        for (i_sel = 0; i_sel < 4; i_sel = i_sel + 1) begin
            if (ctl_reg[i_sel][`CSW_EN_BIT]) begin          // [RULE7]
                if (ctl_reg[i_sel][`CSW_IO_BIT]) begin      // [RULE14]
                    // I/O type: bits 11:4 only, top byte ignored [RULE5]
                    sel_next[i_sel] = cycle_io_in &&    // [RULE3] [RULE7]
                        !periph_hit &&                  // [RULE9]
                        (cycle_addr_in[11:4] == lbr_reg[i_sel]); // [RULE4]
                end else begin
                    // Memory type: never during an I/O instruction
                    sel_next[i_sel] = !cycle_io_in &&
                        mem_match(cycle_addr_in[23:16],
                                  lbr_reg[i_sel], ubr_reg[i_sel]); // [RULE11]
                end
            end
        end
        sel_next  = first_hit(sel_next);                    // [RULE8] [RULE6]
        // Strobe follows any external I/O cycle
        io_request_strobe_next = cycle_io_in && !periph_hit;             // [RULE10]
    end

    // Wait count loaded from the winning select, zero if none
    always @* begin
        wait_next = `CSW_WAIT_ZERO;
        for (i_wait = 3; i_wait >= 0; i_wait = i_wait - 1) begin
            if (sel_next[i_wait]) begin
                wait_next = wait_of(ctl_reg[i_wait]);       // [RULE13]
            end
        end
    end

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************

    // Idle takes a request; active holds until the waits run out
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cycle_start_in) begin
                    state_next = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (wait_reg == `CSW_WAIT_ZERO) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer and pin registers
    // ****************************************************************

    // Drives the pins for one clock plus one clock per wait state
    always @(posedge clock_in) begin
        if (srst_in) begin
            state_reg               <= ST_IDLE;
            wait_reg                <= `CSW_WAIT_ZERO;
            addr_out                <= 24'h00_0000;
            select_out_zero_n_out   <= 1'b1;
            select_out_one_n_out    <= 1'b1;
            select_out_two_n_out    <= 1'b1;
            select_out_three_n_out  <= 1'b1;
            io_request_strobe_n_out <= 1'b1;
            cycle_busy_out          <= 1'b0;
            cycle_done_out          <= 1'b0;
            reg_rdata_out           <= `CSW_RD_IDLE;
        end else begin
            state_reg      <= state_next;
            cycle_done_out <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (cycle_start_in) begin
                        // Top byte forced to zero on I/O cycles
                        addr_out <= cycle_io_in ?
                            {`CSW_TOP_ZERO, cycle_addr_in[15:0]} :
                            cycle_addr_in;                  // [RULE1]
                        select_out_zero_n_out   <= ~sel_next[0];
                        select_out_one_n_out    <= ~sel_next[1];
                        select_out_two_n_out    <= ~sel_next[2];
                        select_out_three_n_out  <= ~sel_next[3];
                        io_request_strobe_n_out <= ~io_request_strobe_next; // [RULE10]
                        wait_reg                <= wait_next;
                        cycle_busy_out          <= 1'b1;
                        // Reads of unmapped addresses give zero
                        reg_rdata_out <= periph_hit ? rd_next :
                            `CSW_RD_IDLE;                   // [RULE2]
                    end
                end
                ST_ACTIVE: begin
                    if (wait_reg == `CSW_WAIT_ZERO) begin
                        // Last clock of the cycle: release selects and strobe, address held
                        select_out_zero_n_out   <= 1'b1;
                        select_out_one_n_out    <= 1'b1;
                        select_out_two_n_out    <= 1'b1;
                        select_out_three_n_out  <= 1'b1;
                        io_request_strobe_n_out <= 1'b1;
                        cycle_busy_out          <= 1'b0;
                        cycle_done_out          <= 1'b1;
                    end else begin
                        // Pins held, one clock per wait state
                        wait_reg <= wait_reg - 3'd1;        // [RULE16]
                    end
                end
                default: begin
                    cycle_busy_out <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Select register writes
    // ****************************************************************

    // Only implemented registers change; other peripheral writes drop
    always @(posedge clock_in) begin
        if (srst_in) begin
            ctl_reg[0] <= `CSW_CTL0_RST;                    // [RULE15]
            ctl_reg[1] <= `CSW_CTLN_RST;
            ctl_reg[2] <= `CSW_CTLN_RST;
            ctl_reg[3] <= `CSW_CTLN_RST;
            for (i_rst = 0; i_rst < 4; i_rst = i_rst + 1) begin
                lbr_reg[i_rst] <= `CSW_BOUND_RST;
                ubr_reg[i_rst] <= `CSW_BOUND_RST;
            end
        end else if (state_reg == ST_IDLE && cycle_start_in &&
                     cycle_write_in && periph_hit && reg_hit) begin // [RULE2]
            // A write takes effect at the start of its cycle, so the
            // next cycle already decodes with the new value
            case (reg_kind)
                2'd0:    lbr_reg[reg_idx] <= cycle_wdata_in;
                2'd1:    ubr_reg[reg_idx] <= cycle_wdata_in;
                default: ctl_reg[reg_idx] <= cycle_wdata_in;
            endcase
        end
    end

endmodule // csw_decoder

// ---- csw_decoder_props.sv ----
// Port assertions and cover points for the select decoder
`timescale 1ns/10ps
module csw_decoder_props (
    input wire logic        clock_in,
    input wire logic        srst_in,
    input wire logic        cycle_start_in,
    input wire logic        cycle_io_in,
    input wire logic        cycle_write_in,
    input wire logic [23:0] cycle_addr_in,
    input wire logic [7:0]  cycle_wdata_in,
    input wire logic [23:0] addr_out,
    input wire logic        select_out_zero_n_out,
    input wire logic        select_out_one_n_out,
    input wire logic        select_out_two_n_out,
    input wire logic        select_out_three_n_out,
    input wire logic        io_request_strobe_n_out,
    input wire logic        cycle_busy_out,
    input wire logic        cycle_done_out,
    input wire logic [7:0]  reg_rdata_out
);
    // ****************************************************************
    // Shared clocking and helper terms
    // ****************************************************************
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    // Selects packed 3..0, active low
    wire logic [3:0] sel_n = {select_out_three_n_out, select_out_two_n_out,
                              select_out_one_n_out, select_out_zero_n_out};
    // Request taken only when idle
    wire logic       take  = cycle_start_in & ~cycle_busy_out;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_io_addr_zero: assert property (take && cycle_io_in |=>
        addr_out == {8'h00, $past(cycle_addr_in[15:0])})
        else $error("io cycle address top byte not zero");
    a_mem_no_strobe: assert property (take && !cycle_io_in |=>
        io_request_strobe_n_out) else $error("strobe on memory cycle");
    a_periph_quiet: assert property (
        take && cycle_io_in && cycle_addr_in[7] |=>
        (sel_n == 4'hF) && io_request_strobe_n_out)
        else $error("external select on peripheral range");
    a_io_strobe_low: assert property (
        take && cycle_io_in && !cycle_addr_in[7] |=>
        !io_request_strobe_n_out) else $error("io strobe missing");
    a_one_select: assert property ($countones(~sel_n) <= 1)
        else $error("more than one select low");
    a_wait_bound: assert property ($rose(cycle_busy_out) |->
        ##[1:8] cycle_done_out) else $error("cycle longer than 7 waits");
    a_pins_hold: assert property (cycle_busy_out ##1 cycle_busy_out
        |-> $stable(sel_n) && $stable(addr_out))
        else $error("pins moved inside a cycle");
    a_done_release: assert property (cycle_done_out |->
        !cycle_busy_out && sel_n == 4'hF) else $error("pins held at end");

    // Main scenarios reached
    c_io_take: cover property (take && cycle_io_in);
    c_mem_take: cover property (take && !cycle_io_in);
    c_long_wait: cover property ($rose(cycle_busy_out) ##8 cycle_done_out);
endmodule // csw_decoder_props

bind csw_decoder csw_decoder_props u_props (.clock_in, .srst_in,
    .cycle_start_in, .cycle_io_in, .cycle_write_in, .cycle_addr_in,
    .cycle_wdata_in, .addr_out, .select_out_zero_n_out,
    .select_out_one_n_out, .select_out_two_n_out, .select_out_three_n_out,
    .io_request_strobe_n_out, .cycle_busy_out, .cycle_done_out,
    .reg_rdata_out);

// ---- csw_ext_dev.sv ----
// Model of the external memory and I/O chips behind the select lines
`timescale 1ns/10ps
module csw_ext_dev (
    input  wire logic       clock_in,    // System clock
    input  wire logic [3:0] sel_n_in,    // Selects 3..0, active low
    input  wire logic       strobe_n_in, // I/O strobe, active low
    output logic      [4:0] seen_out     // Last access: strobe, selects
);
    // Chips only notice a cycle while one of them is selected
    initial seen_out = 5'h00;
    always @(posedge clock_in) begin
        if (sel_n_in != 4'hF) begin
            seen_out <= {~strobe_n_in, ~sel_n_in};
        end
    end
endmodule // csw_ext_dev

// ---- csw_decoder_test.sv ----
// Self-checking testbench of the select decoder
`timescale 1ns/10ps
module csw_decoder_test;
    // ****************************************************************
    // Stimulus, observed pins and score
    // ****************************************************************
    logic        clock_in = 1'b0;       // 200 MHz clock
    logic        srst_in = 1'b1;        // Reset held at start
    logic        cycle_start_in = 1'b0; // Request pulse
    logic        cycle_io_in = 1'b0;    // I/O or memory
    logic        cycle_write_in = 1'b0; // Write or read
    logic [23:0] cycle_addr_in = 24'h00_0000;
    logic [7:0]  cycle_wdata_in = 8'h00;
    wire  [23:0] addr_out;
    wire  [3:0]  sel_n;                 // Selects 3..0, active low
    wire         strobe_n;
    wire         busy;
    wire         done;
    wire  [7:0]  rdata;
    wire  [4:0]  dev_seen;              // What the chips saw last
    logic [3:0]  got_sel;
    logic        got_stb;
    logic        got_busy;              // Busy seen after the taking edge
    logic [23:0] got_addr;
    int          got_wait;
    int          n_mismatch = 0;
    int          checks = 0;
    always #2.5 clock_in = ~clock_in;

    csw_decoder u_dut (.clock_in(clock_in), .srst_in(srst_in),
        .cycle_start_in(cycle_start_in), .cycle_io_in(cycle_io_in),
        .cycle_write_in(cycle_write_in), .cycle_addr_in(cycle_addr_in),
        .cycle_wdata_in(cycle_wdata_in), .addr_out(addr_out),
        .select_out_zero_n_out(sel_n[0]), .select_out_one_n_out(sel_n[1]),
        .select_out_two_n_out(sel_n[2]), .select_out_three_n_out(sel_n[3]),
        .io_request_strobe_n_out(strobe_n), .cycle_busy_out(busy),
        .cycle_done_out(done), .reg_rdata_out(rdata));
    csw_ext_dev u_dev (.clock_in(clock_in), .sel_n_in(sel_n),
        .strobe_n_in(strobe_n), .seen_out(dev_seen));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle; pins are sampled 1 ns after the taking edge
    task automatic bus(input logic i, w, input logic [23:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge clock_in);
        cycle_start_in <= 1'b1;
        cycle_io_in <= i;
        cycle_write_in <= w;
        cycle_addr_in <= a;
        cycle_wdata_in <= d;
        @(posedge clock_in);
        cycle_start_in <= 1'b0;
        #1;
        got_sel = ~sel_n;
        got_stb = strobe_n;
        got_addr = addr_out;
        got_busy = busy;
        n = 0;
        // Bounded wait: a hung cycle ends the run
        while (done !== 1'b1 && n < 20) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        got_wait = n - 1;
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
    endtask
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        bus(1'b1, 1'b1, {16'h0000, o}, d);
    endtask
    // Read cycle judged on strobe, active selects and wait count
    task automatic acc(input logic i, input logic [23:0] a,
                       input logic [3:0] s, wt, input logic stb);
        bus(i, 1'b0, a, 8'h00);
        chk({14'h0, got_busy, got_stb, got_sel, got_wait[3:0]},
            {14'h0, 1'b1, stb, s, wt});
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 1'b0, {16'h0000, 8'hAA + 8'(3 * k)}, 8'h00);
            chk({16'h0, rdata}, (k == 0) ? 24'hE8 : 24'h00);
        end
        acc(1'b0, 24'h00_1234, 4'h1, 4'h7, 1'b1);
        acc(1'b0, 24'h01_0000, 4'h0, 4'h0, 1'b1);
        wr(8'h85, 8'h5A);
        bus(1'b1, 1'b0, 24'hFF_00AA, 8'h00);
        chk({16'h0, rdata}, 24'hE8);
        chk(got_addr, 24'h00_00AA);
    endtask
    task automatic t_mem;
        wr(8'hAE, 8'hA0);
        wr(8'hAF, 8'hCF);
        wr(8'hB0, 8'h48);
        acc(1'b0, 24'hA0_0000, 4'h4, 4'h2, 1'b1);
        acc(1'b0, 24'hCF_FFFF, 4'h4, 4'h2, 1'b1);
        acc(1'b0, 24'h9F_FFFF, 4'h0, 4'h0, 1'b1);
        acc(1'b0, 24'hD0_0000, 4'h0, 4'h0, 1'b1);
        // Every wait code, including both ends of the field
        for (int w = 0; w < 8; w++) begin
            wr(8'hB0, {3'(w), 5'h08});
            acc(1'b0, 24'hB0_0000, 4'h4, 4'(w), 1'b1);
        end
        wr(8'hB0, 8'h00);
    endtask
    task automatic t_io;
        wr(8'hAB, 8'h12);
        wr(8'hAD, 8'h18);
        acc(1'b1, 24'hFF_0120, 4'h2, 4'h0, 1'b0);
        chk(got_addr, 24'h00_0120);
        chk({19'h0, dev_seen}, 24'h12);
        acc(1'b0, 24'h12_0120, 4'h0, 4'h0, 1'b1);
        acc(1'b1, 24'h00_0130, 4'h0, 4'h0, 1'b0);
        wr(8'hAD, 8'h10);
        acc(1'b1, 24'h00_0120, 4'h0, 4'h0, 1'b0);
        wr(8'hAC, 8'h12);
        wr(8'hAD, 8'h08);
        acc(1'b1, 24'h00_0120, 4'h0, 4'h0, 1'b0);
        acc(1'b0, 24'h12_0000, 4'h2, 4'h0, 1'b1);
        wr(8'hAB, 8'h18);
        wr(8'hAD, 8'h38);
        acc(1'b1, 24'h00_0180, 4'h0, 4'h0, 1'b1);
    endtask
    task automatic t_prio;
        wr(8'hAB, 8'h12);
        wr(8'hAD, 8'h18);
        wr(8'hB1, 8'h12);
        wr(8'hB3, 8'h78);
        acc(1'b1, 24'h00_0120, 4'h2, 4'h0, 1'b0);
        wr(8'hAD, 8'h00);
        acc(1'b1, 24'h00_0120, 4'h8, 4'h3, 1'b0);
    endtask

    // Single place where the run ends
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock_in);
        srst_in <= 1'b0;
        t_reset();
        t_mem();
        t_io();
        t_prio();
        summarize();
    end
endmodule // csw_decoder_test
